// >>> mmu_params.svh
// What this block does
// - five exclusive cpu modes tag accesses
// - entries hold rwx, bounds, relocation offset
// - entries hold hardware register group rights
// - entry without permissions matches nothing
// - works with zero to 64 segments
// - cpu addresses translated in user mode before reaching memory; other modes pass them unchanged
// - check completes before memory access
// - fetch, read, write checked on all memories
// - memories split; segments only in application
// - table pointer held in segmentation registers
// - register accesses checked by active mode
// - user rights from segment, firmware from firewall
// - denied register access raises exception
// - firewall defines exchange ram base, size
// - ungranted hardware registers stay unreachable in user and firmware modes; boot, test and system modes reach all of them
// - copy machine gets same checks
// - crypto coprocessor reaches operand ram directly
// - segmentation registers only in system mode
// - copy machine keeps its start mode
`ifndef MMU_PARAMS_SVH
`define MMU_PARAMS_SVH
`define SEG_COUNT 64
`define SEG_IDX_W 6
`define ADDR_W 24
`define HW_GRP_W 16
`define HW_GRP_IDX_W 4
// physical map: rom, eeprom, ram windows
`define ROM_BASE 24'h000000
`define ROM_APP_BASE 24'h040000
`define ROM_END 24'h07ffff
`define EE_BASE 24'h080000
`define EE_APP_BASE 24'h090000
`define EE_END 24'h0fffff
`define RAM_BASE 24'h100000
`define RAM_APP_BASE 24'h101000
`define RAM_END 24'h10ffff
`define CRYPTO_RAM_BASE 24'h110000
`define CRYPTO_RAM_END 24'h1107ff
`endif

// >>> mmu_pkg.sv
package mmu_pkg;
  typedef enum logic [2:0] {
    MODE_BOOT, MODE_TEST, MODE_FIRMWARE, MODE_SYSTEM, MODE_USER
  } cpu_mode_t;
  typedef enum logic [1:0] {OP_FETCH, OP_READ, OP_WRITE} mem_op_t;
  typedef enum logic [2:0] {
    GRP_CPU, GRP_SEGCFG, GRP_SYSMGMT, GRP_FWCFG, GRP_FWOS, GRP_TEST, GRP_HW
  } sfr_group_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic ex;
    logic [23:0] first_addr;
    logic [23:0] last_addr;
    logic [23:0] reloc;
    logic [15:0] hw_rd;
    logic [15:0] hw_wr;
  } seg_entry_t;
  typedef struct packed {
    logic valid;
    mem_op_t op;
    logic [23:0] vaddr;
    logic [7:0] wdata;
  } mem_req_t;
  typedef struct packed {
    logic valid;
    logic wr;
    sfr_group_t grp;
    logic [3:0] hw_idx;
  } sfr_req_t;
  typedef struct packed {
    logic mem_valid;
    mem_op_t mem_op;
    logic [23:0] paddr;
    logic [7:0] wdata;
    logic sfr_grant;
    logic exc;
    logic [1:0] exc_src;
    logic cm_busy;
    cpu_mode_t cm_mode;
    logic [5:0] seg_hit;
    logic [23:0] table_ptr;
  } mmu_state_t;
endpackage

// >>> mode_based_access_control_mmu.sv
`timescale 1ns/1ps
`include "mmu_params.svh"
module mode_based_access_control_mmu (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // mode and configuration
  input wire mmu_pkg::cpu_mode_t cpu_mode,
  input wire logic [15:0] firmware_firewall_ctrl_low,
  input wire logic [15:0] firmware_firewall_ctrl_high,
  input wire logic [23:0] exchange_ram_base,
  input wire logic [23:0] exchange_ram_size,
  // segment table, supplied as an input to the unit
  input wire mmu_pkg::seg_entry_t [63:0] seg_table,
  input wire logic [5:0] cur_code_seg,
  // segmentation pointer write
  input wire logic table_ptr_we,
  input wire logic [23:0] table_ptr_wdata,
  // cpu memory access
  input wire mmu_pkg::mem_req_t cpu_req,
  // cpu register access
  input wire mmu_pkg::sfr_req_t sfr_req,
  // copy machine
  input wire logic cm_start,
  input wire logic cm_done,
  input wire mmu_pkg::mem_req_t cm_req,
  // crypto coprocessor
  input wire logic crypto_req,
  input wire logic crypto_we,
  input wire logic [10:0] crypto_addr,
  // physical memory side
  output logic mem_valid,
  output mmu_pkg::mem_op_t mem_op,
  output logic [23:0] mem_paddr,
  output logic [7:0] mem_wdata,
  output logic crypto_mem_valid,
  output logic crypto_mem_we,
  output logic [23:0] crypto_mem_paddr,
  // results
  output logic sfr_grant,
  output logic exception,
  output logic [1:0] exception_src,
  output logic cm_busy,
  output logic [5:0] seg_hit,
  output logic [23:0] table_ptr
);
  mmu_pkg::mmu_state_t state_reg;
  mmu_pkg::mmu_state_t state_next;

  ////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo,
                                    input logic [23:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // application region test for a physical address
  function automatic logic in_app(input logic [23:0] a);
    in_app = in_range(a, `ROM_APP_BASE, `ROM_END) ||
             in_range(a, `EE_APP_BASE, `EE_END) ||
             in_range(a, `RAM_APP_BASE, `RAM_END);
  endfunction

  // fixed mode rights outside user mode
  function automatic logic mode_allows(input mmu_pkg::cpu_mode_t m,
                                       input mmu_pkg::mem_op_t op,
                                       input logic [23:0] a,
                                       input logic [23:0] xb,
                                       input logic [23:0] xs);
    logic trom, arom, fee, aee, fram, aram, xram;
    trom = in_range(a, `ROM_BASE, `ROM_APP_BASE - 24'h000001);
    arom = in_range(a, `ROM_APP_BASE, `ROM_END);
    fee = in_range(a, `EE_BASE, `EE_APP_BASE - 24'h000001);
    aee = in_range(a, `EE_APP_BASE, `EE_END);
    fram = in_range(a, `RAM_BASE, `RAM_APP_BASE - 24'h000001);
    aram = in_range(a, `RAM_APP_BASE, `RAM_END);
    xram = aram && (a >= xb) && ((a - xb) < xs);
    mode_allows = 1'b0;
    unique case (m)
      mmu_pkg::MODE_BOOT: begin
        mode_allows = (trom && op != mmu_pkg::OP_WRITE) || fee ||
                      (fram && op != mmu_pkg::OP_FETCH);
      end
      mmu_pkg::MODE_TEST: begin
        mode_allows = ((trom || arom) && op != mmu_pkg::OP_WRITE) || fee || aee ||
                      ((fram || aram) && op != mmu_pkg::OP_FETCH);
      end
      mmu_pkg::MODE_FIRMWARE: begin
        mode_allows = (trom && op != mmu_pkg::OP_WRITE) || fee ||
                      ((fram || xram) && op != mmu_pkg::OP_FETCH);
      end
      mmu_pkg::MODE_SYSTEM: begin
        mode_allows = (arom && op != mmu_pkg::OP_WRITE) || aee ||
                      (aram && op != mmu_pkg::OP_FETCH);
      end
      mmu_pkg::MODE_USER: begin
        mode_allows = 1'b0;
      end
      default: begin
        mode_allows = 1'b0;
      end
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // segment match, two comparators per entry (cpu and copy machine)
  logic [63:0] cpu_match;
  logic [63:0] cm_match;
  logic [5:0] cpu_idx;
  logic [5:0] cm_idx;
  logic cpu_any;
  logic cm_any;

  for (genvar g = 0; g < `SEG_COUNT; g++) begin : g_seg
    logic en;
    assign en = seg_table[g].rd | seg_table[g].wr | seg_table[g].ex;
    assign cpu_match[g] = en &&
      in_range(cpu_req.vaddr, seg_table[g].first_addr, seg_table[g].last_addr);
    assign cm_match[g] = en &&
      in_range(cm_req.vaddr, seg_table[g].first_addr, seg_table[g].last_addr);
  end

  // lowest matching entry wins; zero enabled entries simply misses
  always_comb begin
    cpu_idx = 6'h00;
    cm_idx = 6'h00;
    cpu_any = 1'b0;
    cm_any = 1'b0;
    for (int i = `SEG_COUNT - 1; i >= 0; i--) begin
      if (cpu_match[i]) begin
        cpu_idx = 6'(i);
        cpu_any = 1'b1;
      end
      if (cm_match[i]) begin
        cm_idx = 6'(i);
        cm_any = 1'b1;
      end
    end
  end

  // permission bit for the requested operation
  function automatic logic op_ok(input mmu_pkg::seg_entry_t e, input mmu_pkg::mem_op_t op);
    unique case (op)
      mmu_pkg::OP_FETCH: op_ok = e.ex;
      mmu_pkg::OP_READ: op_ok = e.rd;
      mmu_pkg::OP_WRITE: op_ok = e.wr;
      default: op_ok = 1'b0;
    endcase
  endfunction

  // full check and translation of one request under a given mode
  function automatic logic [24:0] check(input mmu_pkg::cpu_mode_t m,
                                        input mmu_pkg::mem_req_t r,
                                        input logic hit,
                                        input mmu_pkg::seg_entry_t e,
                                        input logic [23:0] xb,
                                        input logic [23:0] xs);
    logic [23:0] pa;
    logic ok;
    if (m == mmu_pkg::MODE_USER) begin
      pa = r.vaddr - e.first_addr + e.reloc;
      ok = hit && op_ok(e, r.op) && in_app(pa);
    end else begin
      pa = r.vaddr;
      ok = mode_allows(m, r.op, pa, xb, xs);
    end
    check = {ok, pa};
  endfunction

  logic [24:0] cpu_chk;
  logic [24:0] cm_chk;
  mmu_pkg::cpu_mode_t cm_eff_mode;
  // a copy running keeps its captured mode
  assign cm_eff_mode = state_reg.cm_busy ? state_reg.cm_mode : cpu_mode;
  assign cpu_chk = check(cpu_mode, cpu_req, cpu_any, seg_table[cpu_idx],
                         exchange_ram_base, exchange_ram_size);
  assign cm_chk = check(cm_eff_mode, cm_req, cm_any, seg_table[cm_idx],
                        exchange_ram_base, exchange_ram_size);

  ////////////////////////////////////////////////////////////////////
  // register access decision
  logic sfr_ok;
  always_comb begin
    logic [31:0] fw_rights;
    mmu_pkg::seg_entry_t ce;
    logic seg_right;
    fw_rights = {firmware_firewall_ctrl_high, firmware_firewall_ctrl_low};
    ce = seg_table[cur_code_seg];
    seg_right = sfr_req.wr ? ce.hw_wr[sfr_req.hw_idx] : ce.hw_rd[sfr_req.hw_idx];
    sfr_ok = 1'b0;
    if (sfr_req.grp == mmu_pkg::GRP_CPU) begin
      sfr_ok = 1'b1;
    end else if (sfr_req.grp == mmu_pkg::GRP_SEGCFG) begin
      sfr_ok = (cpu_mode == mmu_pkg::MODE_SYSTEM);
    end else begin
      unique case (cpu_mode)
        mmu_pkg::MODE_BOOT: sfr_ok = (sfr_req.grp != mmu_pkg::GRP_TEST);
        mmu_pkg::MODE_TEST: sfr_ok = 1'b1;
        mmu_pkg::MODE_FIRMWARE: begin
          // low half read rights, high half write rights
          if (sfr_req.grp == mmu_pkg::GRP_FWOS) begin
            sfr_ok = 1'b1;
          end else if (sfr_req.grp == mmu_pkg::GRP_FWCFG) begin
            sfr_ok = !sfr_req.wr;
          end else if (sfr_req.grp == mmu_pkg::GRP_HW) begin
            sfr_ok = fw_rights[{sfr_req.wr, sfr_req.hw_idx}];
          end
        end
        mmu_pkg::MODE_SYSTEM: begin
          sfr_ok = (sfr_req.grp == mmu_pkg::GRP_SYSMGMT) ||
                   (sfr_req.grp == mmu_pkg::GRP_FWCFG) || (sfr_req.grp == mmu_pkg::GRP_HW);
        end
        mmu_pkg::MODE_USER: begin
          sfr_ok = (sfr_req.grp == mmu_pkg::GRP_HW) && seg_right;
        end
        default: sfr_ok = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // next state; one registered stage gates memory behind the check
  always_comb begin
    state_next = state_reg;
    state_next.mem_valid = 1'b0;
    state_next.sfr_grant = 1'b0;
    state_next.exc = 1'b0;
    state_next.exc_src = 2'b00;
    if (table_ptr_we && cpu_mode == mmu_pkg::MODE_SYSTEM) begin
      state_next.table_ptr = table_ptr_wdata;
    end
    // copy engine mode capture, start wins over done only while idle
    if (cm_start && !state_reg.cm_busy) begin
      state_next.cm_busy = 1'b1;
      state_next.cm_mode = cpu_mode;
    end else if (cm_done) begin
      state_next.cm_busy = 1'b0;
    end
    // cpu has priority on the memory port; a copy request in the same cycle is dropped
    if (cpu_req.valid) begin
      state_next.mem_op = cpu_req.op;
      state_next.paddr = cpu_chk[23:0];
      state_next.wdata = cpu_req.wdata;
      state_next.seg_hit = cpu_idx;
      if (cpu_chk[24]) begin
        state_next.mem_valid = 1'b1;
      end else begin
        state_next.exc = 1'b1;
        state_next.exc_src = 2'b01;
      end
    end else if (cm_req.valid && state_reg.cm_busy) begin
      state_next.mem_op = cm_req.op;
      state_next.paddr = cm_chk[23:0];
      state_next.wdata = cm_req.wdata;
      state_next.seg_hit = cm_idx;
      if (cm_chk[24]) begin
        state_next.mem_valid = 1'b1;
      end else begin
        state_next.exc = 1'b1;
        state_next.exc_src = 2'b11;
      end
    end
    if (sfr_req.valid) begin
      if (sfr_ok) begin
        state_next.sfr_grant = 1'b1;
      end else begin
        state_next.exc = 1'b1;
        state_next.exc_src = 2'b10;
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs
  assign mem_valid = state_reg.mem_valid;
  assign mem_op = state_reg.mem_op;
  assign mem_paddr = state_reg.paddr;
  assign mem_wdata = state_reg.wdata;
  assign sfr_grant = state_reg.sfr_grant;
  assign exception = state_reg.exc;
  assign exception_src = state_reg.exc_src;
  assign cm_busy = state_reg.cm_busy;
  assign seg_hit = state_reg.seg_hit;
  assign table_ptr = state_reg.table_ptr;
  // crypto path bypasses cpu, tied to its own ram window
  assign crypto_mem_valid = crypto_req && rstn;
  assign crypto_mem_we = crypto_we && crypto_req && rstn;
  assign crypto_mem_paddr = `CRYPTO_RAM_BASE | {13'h0000, crypto_addr};
  // mode tag is the single enum input, exclusive by type
endmodule

// >>> mmu_chk.sv
`timescale 1ns/1ps
module mmu_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // requests and configuration
  input wire mmu_pkg::cpu_mode_t cpu_mode,
  input wire mmu_pkg::mem_req_t cpu_req,
  input wire mmu_pkg::sfr_req_t sfr_req,
  input wire logic table_ptr_we,
  input wire logic [23:0] table_ptr_wdata,
  input wire logic cm_done,
  input wire logic crypto_req,
  input wire logic crypto_we,
  // results
  input wire logic mem_valid,
  input wire logic crypto_mem_valid,
  input wire logic crypto_mem_we,
  input wire logic sfr_grant,
  input wire logic exception,
  input wire logic [1:0] exception_src,
  input wire logic cm_busy,
  input wire logic [23:0] table_ptr
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////////
  // steps of each access; cpu access without a register access gets exactly one answer, strobe or exception
  sequence cpu_only; cpu_req.valid && !sfr_req.valid; endsequence
  sequence one_answer; mem_valid ^ exception; endsequence
  sequence seg_probe; sfr_req.valid && sfr_req.grp == mmu_pkg::GRP_SEGCFG; endsequence
  sequence sys_write; table_ptr_we && cpu_mode == mmu_pkg::MODE_SYSTEM; endsequence
  ////////////////////////////////////////////////////////////////////////////////
  mem_answer_a: assert property (cpu_only |=> one_answer)
    else $error("memory request without a single answer");
  mem_quiet_a: assert property (!cpu_req.valid && !cm_busy |=> !mem_valid)
    else $error("memory strobe without a request");
  sfr_answer_a: assert property (sfr_req.valid |=> sfr_grant || exception_src == 2'b10)
    else $error("register access without grant or exception");
  seg_guard_a: assert property ((seg_probe and cpu_mode != mmu_pkg::MODE_SYSTEM) |=> !sfr_grant)
    else $error("segmentation registers granted outside system mode");
  cpu_group_a: assert property (sfr_req.valid && sfr_req.grp == mmu_pkg::GRP_CPU |=> sfr_grant)
    else $error("cpu group access refused");
  ptr_write_a: assert property (sys_write |=> table_ptr == $past(table_ptr_wdata))
    else $error("table pointer not written");
  ptr_keep_a: assert property (!(table_ptr_we && cpu_mode == mmu_pkg::MODE_SYSTEM)
                               |=> $stable(table_ptr))
    else $error("table pointer changed outside system mode");
  copy_hold_a: assert property (cm_busy && !cm_done |=> cm_busy)
    else $error("copy machine dropped busy");
  crypto_path_a: assert property (crypto_req |-> crypto_mem_valid && crypto_mem_we == crypto_we)
    else $error("crypto request not passed to operand ram");
endmodule
bind mode_based_access_control_mmu mmu_chk u_chk (.*);

// >>> access_master.sv
`timescale 1ns/1ps
module access_master (
  // clock
  input wire logic sys_clk,
  // command from the bench
  input wire logic go,
  input wire logic to_cm,
  input wire mmu_pkg::mem_req_t req,
  // requests toward the unit
  output mmu_pkg::mem_req_t cpu_req,
  output mmu_pkg::mem_req_t cm_req
);
  initial begin
    cpu_req = '0;
    cm_req = '0;
  end
  // one-cycle pulse; released fields turn over so stale values never look valid
  always @(posedge sys_clk) begin
    cpu_req <= '{1'b0, cpu_req.op, ~cpu_req.vaddr, ~cpu_req.wdata};
    cm_req <= '{1'b0, cm_req.op, ~cm_req.vaddr, ~cm_req.wdata};
    if (go && !to_cm) begin
      cpu_req <= req;
    end
    if (go && to_cm) begin
      cm_req <= req;
    end
  end
endmodule

// >>> mode_based_access_control_mmu_test.sv
`timescale 1ns/1ps
`include "mmu_params.svh"
module mode_based_access_control_mmu_test;
  logic sys_clk = 1'b0, rstn = 1'b0, go = 1'b0, to_cm = 1'b0;
  mmu_pkg::cpu_mode_t cpu_mode = mmu_pkg::MODE_SYSTEM;
  logic [15:0] firmware_firewall_ctrl_low = 16'h0008, firmware_firewall_ctrl_high = 16'h0000;
  logic [23:0] exchange_ram_base = 24'h102000, exchange_ram_size = 24'h000100;
  mmu_pkg::seg_entry_t [63:0] seg_table = '0;
  logic [5:0] cur_code_seg = 6'h01;
  logic table_ptr_we = 1'b0, cm_start = 1'b0, cm_done = 1'b0;
  logic [23:0] table_ptr_wdata = 24'h000000;
  mmu_pkg::sfr_req_t sfr_req = '0;
  mmu_pkg::mem_req_t cpu_req, cm_req, req = '0;
  logic crypto_req = 1'b0, crypto_we = 1'b0;
  logic [10:0] crypto_addr = 11'h000;
  logic mem_valid, crypto_mem_valid, crypto_mem_we, sfr_grant, exception, cm_busy;
  mmu_pkg::mem_op_t mem_op;
  logic [23:0] mem_paddr, crypto_mem_paddr, table_ptr;
  logic [7:0] mem_wdata;
  logic [1:0] exception_src;
  logic [5:0] seg_hit;
  int num_errors = 0, checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  mode_based_access_control_mmu u_dut (.*);
  access_master u_master (.sys_clk(sys_clk), .go(go), .to_cm(to_cm), .req(req),
    .cpu_req(cpu_req), .cm_req(cm_req));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one access through the master; bounded wait, a silent unit counts as a fault
  task automatic mem(string what, mmu_pkg::mem_op_t op, mmu_pkg::cpu_mode_t m,
                     logic [23:0] va, logic ok, logic [23:0] pa, logic cm);
    int i;
    @(posedge sys_clk);
    cpu_mode <= m;
    req <= '{1'b1, op, va, 8'h5a};
    to_cm <= cm;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    for (i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      #1;
      if (mem_valid === 1'b1 || exception === 1'b1) break;
    end
    if (i == 8) begin
      num_errors++;
      conclude();
    end
    check({what, "_ok"}, mem_valid, ok);
    check({what, "_op"}, mem_op, op);
    if (ok) check({what, "_wd"}, mem_wdata, 8'h5a);
    if (ok) check({what, "_pa"}, mem_paddr, pa);
    else check({what, "_src"}, exception_src, cm ? 2'b11 : 2'b01);
  endtask
  // register access answered on the cycle after it is taken
  task automatic sfr(string what, mmu_pkg::cpu_mode_t m, logic wr, mmu_pkg::sfr_group_t g,
                     logic [3:0] idx, logic ok);
    @(posedge sys_clk);
    cpu_mode <= m;
    sfr_req <= '{1'b1, wr, g, idx};
    @(posedge sys_clk);
    sfr_req.valid <= 1'b0;
    #1;
    check({what, "_grant"}, sfr_grant, ok);
    check({what, "_exc"}, exception, !ok);
  endtask
  task automatic ptr(mmu_pkg::cpu_mode_t m, logic [23:0] d, logic [23:0] exp);
    @(posedge sys_clk);
    cpu_mode <= m;
    table_ptr_we <= 1'b1;
    table_ptr_wdata <= d;
    @(posedge sys_clk);
    table_ptr_we <= 1'b0;
    @(posedge sys_clk);
    #1;
    check("table_ptr", table_ptr, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // entry 0 covers everything but grants no rwx, so it must never match
  initial begin
    seg_table[0] = '{1'b0, 1'b0, 1'b0, 24'h000000, 24'hffffff, 24'h000000, 16'hffff, 16'hffff};
    seg_table[1] = '{1'b1, 1'b0, 1'b0, 24'h001000, 24'h001fff, `RAM_APP_BASE, 16'h0004, 16'h0};
    repeat (4) @(posedge sys_clk);
    #1;
    check("rst_ptr", table_ptr, 24'h0);
    check("rst_busy", cm_busy, 1'b0);
    @(posedge sys_clk);
    rstn <= 1'b1;
    mem("sys_fetch", mmu_pkg::OP_FETCH, mmu_pkg::MODE_SYSTEM, `ROM_APP_BASE, 1'b1, `ROM_APP_BASE, 1'b0);
    mem("sys_test_rom", mmu_pkg::OP_READ, mmu_pkg::MODE_SYSTEM, `ROM_BASE, 1'b0, 24'h0, 1'b0);
    mem("usr_read", mmu_pkg::OP_READ, mmu_pkg::MODE_USER, 24'h001010, 1'b1, 24'h101010, 1'b0);
    check("usr_seg", seg_hit, 6'h01);
    mem("usr_write", mmu_pkg::OP_WRITE, mmu_pkg::MODE_USER, 24'h001010, 1'b0, 24'h0, 1'b0);
    mem("usr_miss", mmu_pkg::OP_READ, mmu_pkg::MODE_USER, 24'h002000, 1'b0, 24'h0, 1'b0);
    mem("fw_xchg", mmu_pkg::OP_READ, mmu_pkg::MODE_FIRMWARE, 24'h102010, 1'b1, 24'h102010, 1'b0);
    mem("fw_out", mmu_pkg::OP_WRITE, mmu_pkg::MODE_FIRMWARE, 24'h102100, 1'b0, 24'h0, 1'b0);
    for (int k = 0; k < 5; k++) begin
      sfr("segcfg", mmu_pkg::cpu_mode_t'(k), 1'b0, mmu_pkg::GRP_SEGCFG, 4'h0, k == 3);
      sfr("cpu_grp", mmu_pkg::cpu_mode_t'(k), 1'b1, mmu_pkg::GRP_CPU, 4'h0, 1'b1);
      sfr("test_grp", mmu_pkg::cpu_mode_t'(k), 1'b0, mmu_pkg::GRP_TEST, 4'h0, k == 1);
    end
    sfr("usr_hw_rd", mmu_pkg::MODE_USER, 1'b0, mmu_pkg::GRP_HW, 4'h2, 1'b1);
    sfr("usr_hw_wr", mmu_pkg::MODE_USER, 1'b1, mmu_pkg::GRP_HW, 4'h2, 1'b0);
    sfr("fw_hw_rd", mmu_pkg::MODE_FIRMWARE, 1'b0, mmu_pkg::GRP_HW, 4'h3, 1'b1);
    sfr("fw_hw_no", mmu_pkg::MODE_FIRMWARE, 1'b0, mmu_pkg::GRP_HW, 4'h2, 1'b0);
    ptr(mmu_pkg::MODE_USER, 24'h123456, 24'h000000);
    ptr(mmu_pkg::MODE_SYSTEM, 24'h00abcd, 24'h00abcd);
    // copy started in system mode keeps it after software drops to user mode
    @(posedge sys_clk);
    cpu_mode <= mmu_pkg::MODE_SYSTEM;
    cm_start <= 1'b1;
    @(posedge sys_clk);
    cm_start <= 1'b0;
    mem("cm_keep", mmu_pkg::OP_READ, mmu_pkg::MODE_USER, `ROM_APP_BASE, 1'b1, `ROM_APP_BASE, 1'b1);
    mem("cm_deny", mmu_pkg::OP_READ, mmu_pkg::MODE_USER, `ROM_BASE, 1'b0, 24'h0, 1'b1);
    @(posedge sys_clk);
    cm_done <= 1'b1;
    @(posedge sys_clk);
    cm_done <= 1'b0;
    #1;
    check("cm_idle", cm_busy, 1'b0);
    // crypto path reaches operand ram with no cpu request
    @(posedge sys_clk);
    crypto_req <= 1'b1;
    crypto_we <= 1'b1;
    crypto_addr <= 11'h015;
    @(posedge sys_clk);
    #1;
    check("crypto_pa", crypto_mem_paddr, `CRYPTO_RAM_BASE | 24'h000015);
    crypto_req <= 1'b0;
    seg_table <= '0;
    mem("no_segs", mmu_pkg::OP_READ, mmu_pkg::MODE_USER, 24'h001010, 1'b0, 24'h0, 1'b0);
    conclude();
  end
endmodule
